// ==== scra_client.v ====
/*
 Serial client register access: two-wire client with a 256-byte register
 space and auto-incrementing pointer, stand-alone strap handling, and an
 APB slave for configuration, status and interrupts.
 Assumes the clock and data pins arrive asynchronously and are oversampled
 by ref_clk_in at least eight times per link bit.
*/
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "scra_map.vh"
module scra_client #(
	parameter [6:0] CLIENT_ADDR = `SCRA_RST_ADDR,
	parameter PTR_W = 8
) (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	output reg irq_out,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n_out,
	input wire interface_mode_strap_in,
	input wire fault_hold_strap_in,
	input wire attach_detect_strap_in,
	input wire port_power_enable_in,
	input wire emulation_enable_in,
	input wire emulation_profile_bit0_in,
	input wire emulation_profile_bit1_in,
	input wire fault_in,
	input wire attach_sense_in,
	output reg port_switch_on_out,
	output reg [2:0] emulation_select_out,
	output reg fault_notify_n_out,
	output reg attach_detect_n_out
);

	function [PTR_W-1:0] ptr_next;
		input [PTR_W-1:0] p;
		begin
			ptr_next = p + {{(PTR_W-1){1'b0}}, 1'b1};
		end
	endfunction

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	reg [9:0] meta_q;
	reg [9:0] sync_q;
	reg scl_d1_q;
	reg sda_d1_q;
	reg ppe_d1_q;
	wire scl_s = sync_q[0];
	wire sda_s = sync_q[1];
	wire ppe_s = sync_q[4];
	wire fault_s = sync_q[9];

	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q <= `SCRA_RST_PINS;
			sync_q <= `SCRA_RST_PINS;
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
			ppe_d1_q <= 1'b0;
		end else begin
			meta_q <= {fault_in, attach_sense_in, emulation_profile_bit1_in,
				emulation_profile_bit0_in, emulation_enable_in, port_power_enable_in,
				attach_detect_strap_in, fault_hold_strap_in, sda_in, scl_in};
			sync_q <= meta_q;
			scl_d1_q <= scl_s;
			sda_d1_q <= sda_s;
			ppe_d1_q <= ppe_s;
		end
	end

	wire scl_rise = scl_s & ~scl_d1_q;
	wire scl_fall = ~scl_s & scl_d1_q;
	wire start_det = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
	wire stop_det = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

	// ==========================================================
	// Strap capture after reset release
	// ==========================================================
	reg [1:0] strap_meta_q;
	reg strap_taken_q;
	reg standalone_q;
	reg hold_strap_q;
	reg attach_strap_q;
	reg [1:0] strap_cnt_q;

	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			strap_meta_q <= 2'h0;
			strap_cnt_q <= 2'h0;
			strap_taken_q <= 1'b0;
			standalone_q <= 1'b0;
			hold_strap_q <= 1'b0;
			attach_strap_q <= 1'b0;
		end else begin
			strap_meta_q <= {strap_meta_q[0], interface_mode_strap_in};
			if (!strap_taken_q) begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
				strap_taken_q <= (strap_cnt_q == `SCRA_STRAP_WAIT);
				standalone_q <= strap_meta_q[1];
				hold_strap_q <= sync_q[2];
				attach_strap_q <= sync_q[3];
			end
		end
	end

	// ==========================================================
	// Link state machine and register space
	// ==========================================================
	reg [7:0] regs_mem [0:(1<<PTR_W)-1];
	reg [2:0] state_q;
	reg [1:0] kind_q;
	reg [2:0] bit_cnt_q;
	reg byte_full_q;
	reg [7:0] shift_q;
	reg [7:0] tx_q;
	reg rw_q;
	reg host_ack_q;
	reg [PTR_W-1:0] ptr_q;
	reg [6:0] client_addr_q;
	reg ev_wr_q;
	reg ev_rd_q;
	reg ev_stop_q;
	wire link_on = strap_taken_q & ~standalone_q;
	wire addr_hit = (shift_q[7:1] == client_addr_q);

	always @(posedge ref_clk_in) begin
		if (link_on && state_q == `SCRA_S_RX && scl_fall && byte_full_q &&
			kind_q == `SCRA_K_DATA) begin
			regs_mem[ptr_q] <= shift_q;
		end
	end

	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= `SCRA_S_IDLE;
			kind_q <= `SCRA_K_ADDR;
			bit_cnt_q <= 3'h0;
			byte_full_q <= 1'b0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			rw_q <= 1'b0;
			host_ack_q <= 1'b0;
			ptr_q <= `SCRA_RST_PTR;
			sda_oe_n_out <= 1'b1;
			sda_out <= 1'b0;
			ev_wr_q <= 1'b0;
			ev_rd_q <= 1'b0;
			ev_stop_q <= 1'b0;
		end else begin
			ev_wr_q <= 1'b0;
			ev_rd_q <= 1'b0;
			ev_stop_q <= 1'b0;
			sda_out <= 1'b0;
			if (!link_on) begin
				state_q <= `SCRA_S_IDLE;
				sda_oe_n_out <= 1'b1;
			end else if (stop_det) begin
				state_q <= `SCRA_S_IDLE;
				sda_oe_n_out <= 1'b1;
				ev_stop_q <= (state_q != `SCRA_S_IDLE) && (state_q != `SCRA_S_WAIT);
			end else if (start_det) begin
				state_q <= `SCRA_S_RX;
				kind_q <= `SCRA_K_ADDR;
				bit_cnt_q <= 3'h0;
				byte_full_q <= 1'b0;
				sda_oe_n_out <= 1'b1;
			end else begin
				case (state_q)
				`SCRA_S_RX: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_s};
						bit_cnt_q <= bit_cnt_q + 3'h1;
						byte_full_q <= (bit_cnt_q == `SCRA_LAST_BIT);
					end else if (scl_fall && byte_full_q) begin
						byte_full_q <= 1'b0;
						state_q <= `SCRA_S_RACK;
						sda_oe_n_out <= 1'b0;
						case (kind_q)
						`SCRA_K_ADDR: begin
							rw_q <= shift_q[0];
							if (!addr_hit) begin
								state_q <= `SCRA_S_WAIT;
								sda_oe_n_out <= 1'b1;
							end
						end
						`SCRA_K_REG: ptr_q <= shift_q[PTR_W-1:0];
						default: begin
							ptr_q <= ptr_next(ptr_q);
							ev_wr_q <= 1'b1;
						end
						endcase
					end
				end
				`SCRA_S_RACK: begin
					if (scl_fall) begin
						bit_cnt_q <= 3'h0;
						if (kind_q == `SCRA_K_ADDR && rw_q) begin
							tx_q <= regs_mem[ptr_q];
							sda_oe_n_out <= regs_mem[ptr_q][7];
							state_q <= `SCRA_S_TX;
						end else begin
							sda_oe_n_out <= 1'b1;
							state_q <= `SCRA_S_RX;
							kind_q <= (kind_q == `SCRA_K_ADDR) ? `SCRA_K_REG : `SCRA_K_DATA;
						end
					end
				end
				`SCRA_S_TX: begin
					if (scl_fall) begin
						if (bit_cnt_q == `SCRA_LAST_BIT) begin
							sda_oe_n_out <= 1'b1;
							state_q <= `SCRA_S_TACK;
						end else begin
							tx_q <= {tx_q[6:0], 1'b0};
							sda_oe_n_out <= tx_q[6];
							bit_cnt_q <= bit_cnt_q + 3'h1;
						end
					end
				end
				`SCRA_S_TACK: begin
					if (scl_rise) begin
						host_ack_q <= ~sda_s;
					end else if (scl_fall) begin
						ev_rd_q <= 1'b1;
						bit_cnt_q <= 3'h0;
						if (host_ack_q) begin
							ptr_q <= ptr_next(ptr_q);
							tx_q <= regs_mem[ptr_next(ptr_q)];
							sda_oe_n_out <= regs_mem[ptr_next(ptr_q)][7];
							state_q <= `SCRA_S_TX;
						end else begin
							state_q <= `SCRA_S_WAIT;
						end
					end
				end
				`SCRA_S_WAIT: sda_oe_n_out <= 1'b1;
				default: state_q <= `SCRA_S_IDLE;
				endcase
			end
		end
	end

	// ==========================================================
	// Fault and attach handling
	// ==========================================================
	reg fault_latch_q;
	wire hold_mode = standalone_q & hold_strap_q;
	wire attach_en = ~standalone_q | attach_strap_q;
	wire fault_active = hold_mode ? (fault_latch_q | fault_s) : fault_s;

	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fault_latch_q <= 1'b0;
			port_switch_on_out <= 1'b0;
			emulation_select_out <= 3'h0;
			fault_notify_n_out <= 1'b1;
			attach_detect_n_out <= 1'b1;
		end else begin
			fault_latch_q <= fault_s | (fault_latch_q & (ppe_s == ppe_d1_q));
			port_switch_on_out <= ppe_s & ~fault_active & strap_taken_q;
			emulation_select_out <= {sync_q[5], sync_q[7], sync_q[6]};
			fault_notify_n_out <= ~fault_active;
			attach_detect_n_out <= ~(attach_en & ~ppe_s & sync_q[8]);
		end
	end

	// ==========================================================
	// APB slave, status and interrupt
	// ==========================================================
	reg [`SCRA_ST_W-1:0] status_q;
	reg [`SCRA_ST_W-1:0] mask_q;
	reg [PTR_W-1:0] mem_idx_q;
	reg fault_d1_q;
	wire apb_acc = psel_in & penable_in & ~pready_out;
	wire apb_wr = psel_in & penable_in & pready_out & pwrite_in;
	wire [`SCRA_ST_W-1:0] events = {fault_s & ~fault_d1_q, ev_stop_q, ev_rd_q, ev_wr_q};
	wire [`SCRA_ST_W-1:0] w1c = (apb_wr && paddr_in == `SCRA_OFF_STAT) ?
		pwdata_in[`SCRA_ST_W-1:0] : {`SCRA_ST_W{1'b0}};
	reg [31:0] rd_mux;
	reg rd_err;

	always @* begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr_in)
		`SCRA_OFF_CTRL: rd_mux[6:0] = client_addr_q;
		`SCRA_OFF_STAT: rd_mux[`SCRA_ST_W-1:0] = status_q;
		`SCRA_OFF_MASK: rd_mux[`SCRA_ST_W-1:0] = mask_q;
		`SCRA_OFF_INFO: rd_mux[15:0] = {fault_latch_q, standalone_q, 3'h0, state_q, ptr_q};
		`SCRA_OFF_MIDX: rd_mux[PTR_W-1:0] = mem_idx_q;
		`SCRA_OFF_MDAT: rd_mux[7:0] = regs_mem[mem_idx_q];
		default: rd_err = 1'b1;
		endcase
	end

	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			client_addr_q <= CLIENT_ADDR;
			status_q <= {`SCRA_ST_W{1'b0}};
			mask_q <= `SCRA_RST_MASK;
			mem_idx_q <= `SCRA_RST_PTR;
			fault_d1_q <= 1'b0;
			prdata_out <= 32'h0000_0000;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			fault_d1_q <= fault_s;
			pready_out <= apb_acc;
			pslverr_out <= apb_acc & rd_err;
			prdata_out <= (apb_acc && !pwrite_in) ? rd_mux : 32'h0000_0000;
			status_q <= (status_q & ~w1c) | events;
			irq_out <= |(status_q & mask_q);
			if (apb_wr && paddr_in == `SCRA_OFF_CTRL) begin
				client_addr_q <= pwdata_in[6:0];
			end
			if (apb_wr && paddr_in == `SCRA_OFF_MASK) begin
				mask_q <= pwdata_in[`SCRA_ST_W-1:0];
			end
			if (apb_wr && paddr_in == `SCRA_OFF_MIDX) begin
				mem_idx_q <= pwdata_in[PTR_W-1:0];
			end
		end
	end

endmodule // scra_client

// ==== scra_client_properties.sv ====
/* Port checker for scra_client.
 Assumes a bind from the bench top file. */
`timescale 1ns/10ps
module scra_client_props (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire psel_in,
	input wire penable_in,
	input wire [31:0] prdata_out,
	input wire pready_out,
	input wire pslverr_out,
	input wire scl_in,
	input wire sda_oe_n_out,
	input wire interface_mode_strap_in,
	input wire port_power_enable_in,
	input wire port_switch_on_out
);
	// ==========
	// Relations
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_ready_pulse: assert property (pready_out |=> !pready_out) else $error("pready long");
	chk_ready_wait: assert property ($rose(penable_in) |-> !pready_out ##1 pready_out)
		else $error("pready late");
	chk_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in))
		else $error("pready uncaused");
	chk_slverr_pair: assert property (pslverr_out |-> pready_out) else $error("lone pslverr");
	chk_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
		else $error("prdata not zero");
	chk_data_moves: assert property ($changed(sda_oe_n_out) |-> !$past(scl_in))
		else $error("data moved in clock high");
	chk_alone_quiet: assert property (interface_mode_strap_in [*8] |-> sda_oe_n_out)
		else $error("data driven in stand-alone");
	chk_switch_off: assert property (!port_power_enable_in [*5] |-> !port_switch_on_out)
		else $error("switch on while disabled");
endmodule // scra_client_props

// ==== scra_host_model.sv ====
/* Two-wire host model: clock and open-drain data, MSB first.
 Assumes a pull-up on data, combined in the bench. */
`timescale 1ns/10ps
module scra_host_model (
	input wire sda_in,
	output reg scl_out,
	output reg sda_out
);
	// ==========
	// Conditions
	initial begin
		scl_out = 1'h1;
		sda_out = 1'h1;
	end
	task start;
		begin
			#37 sda_out = 1'h1;
			#200 scl_out = 1'h1;
			#200 sda_out = 1'h0;
			#200 scl_out = 1'h0;
			#200;
		end
	endtask
	task stop;
		begin
			#37 sda_out = 1'h0;
			#200 scl_out = 1'h1;
			#200 sda_out = 1'h1;
			#400;
		end
	endtask
	// ==========
	// Bits and bytes
	task bitx(input reg v, output reg r);
		begin
			sda_out = v;
			#200 scl_out = 1'h1;
			#200 r = sda_in;
			#200 scl_out = 1'h0;
			#200;
		end
	endtask
	task wbyte(input reg [7:0] d, output reg ack);
		integer i;
		reg r;
		begin
			for (i = 7; i >= 0; i = i - 1)
				bitx(d[i], r);
			bitx(1'h1, r);
			ack = !r;
		end
	endtask
	task rbyte(input reg last, output reg [7:0] d);
		integer i;
		reg r;
		begin
			for (i = 7; i >= 0; i = i - 1)
				bitx(1'h1, d[i]);
			bitx(last, r);
		end
	endtask
endmodule // scra_host_model

// ==== scra_map.vh ====
/*
 Constants for the serial client register access block: link states,
 byte kinds, APB offsets, status bit positions and reset values.
 Assumes it is included once per design file by its bare name.
*/
// Notes on behaviour
// - A write byte is address+0, index, data, each acknowledged with a driven 0.
// - A read byte writes the index, restarts with address+1, gets one byte, NACK, STOP.
// - A write with only an index then STOP loads the pointer and changes no register.
// - A read with no index returns the register at the pointer and leaves it there.
// - Each byte of a multi-byte write is stored at the pointer, which then wraps up by one.
// - A multi-byte read returns consecutive registers, the pointer wrapping FFh to 00h.
// - Block transfers carry no byte count; the host's STOP sets the length.
// - A strap sensed as a large pull-down puts the device in stand-alone mode.
// - Stand-alone: fault-hold strap low auto-recovers, high latches until enable changes.
// - Stand-alone: attach-detect strap high enables attach detection in detect state.
// - Stand-alone control and status pass only through the dedicated pins.
// - The first byte after START is a 7-bit client address and a direction bit.
// - Every byte is eight bits, most significant bit first.
// - STOP resets the client state machine, ready for a new transaction.
// - The device never holds the clock low.
`ifndef SCRA_MAP_VH
`define SCRA_MAP_VH
// Link states
`define SCRA_S_IDLE 3'h0
`define SCRA_S_RX 3'h1
`define SCRA_S_RACK 3'h2
`define SCRA_S_TX 3'h3
`define SCRA_S_TACK 3'h4
`define SCRA_S_WAIT 3'h5
// Kind of the byte being received
`define SCRA_K_ADDR 2'h0
`define SCRA_K_REG 2'h1
`define SCRA_K_DATA 2'h2
`define SCRA_LAST_BIT 3'h7
// APB offsets
`define SCRA_OFF_CTRL 12'h000
`define SCRA_OFF_STAT 12'h004
`define SCRA_OFF_MASK 12'h008
`define SCRA_OFF_INFO 12'h00c
`define SCRA_OFF_MIDX 12'h010
`define SCRA_OFF_MDAT 12'h014
// Status bits
`define SCRA_ST_WR 0
`define SCRA_ST_RD 1
`define SCRA_ST_STOP 2
`define SCRA_ST_FAULT 3
`define SCRA_ST_W 4
// Reset values
`define SCRA_RST_ADDR 7'h33
`define SCRA_RST_MASK 4'h0
`define SCRA_RST_PTR 8'h00
// Input pins at their idle levels: both link lines high, all others low
`define SCRA_RST_PINS 10'h003
// Edges after reset release before the straps are taken
`define SCRA_STRAP_WAIT 2'h3
`endif

// ==== test_smbus_client_register_access.sv ====
/* Self-checking bench for scra_client over APB and the two-wire link.
 Assumes the checker and host model files are compiled first. */
`timescale 1ns/10ps
module test_smbus_client_register_access;
	// ==========
	// Signals
	reg clk, rst_n, psel, pen, pwr, ms, hs, ast, pw, ee, e0, e1, flt, asn, a, err;
	reg [11:0] pa;
	reg [31:0] pwd, rv;
	reg [7:0] b;
	wire [31:0] prd;
	wire [2:0] esel;
	wire prdy, perr, irq, scl, hsda, so, soe_n, sw, fn_n, ad_n;
	wire sda = hsda & (soe_n | so);
	integer n_mismatch = 0, checks_done = 0, cyc = 0, i, k;
	scra_client dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
		.pslverr_out(perr), .irq_out(irq), .scl_in(scl), .sda_in(sda), .sda_out(so),
		.sda_oe_n_out(soe_n), .interface_mode_strap_in(ms), .fault_hold_strap_in(hs),
		.attach_detect_strap_in(ast), .port_power_enable_in(pw), .emulation_enable_in(ee),
		.emulation_profile_bit0_in(e0), .emulation_profile_bit1_in(e1), .fault_in(flt),
		.attach_sense_in(asn), .port_switch_on_out(sw), .emulation_select_out(esel),
		.fault_notify_n_out(fn_n), .attach_detect_n_out(ad_n));
	scra_host_model host_u (.sda_in(sda), .scl_out(scl), .sda_out(hsda));
	// ==========
	// Tasks
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("Error %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task finish_test;
		begin
			$display("Mismatches %0d checks %0d", n_mismatch, checks_done);
			if (n_mismatch == 0 && checks_done > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task apb(input w, input [11:0] ad, input [31:0] d);
		begin
			@(posedge clk);
			psel <= 1'h1;
			pwr <= w;
			pa <= ad;
			pwd <= d;
			@(posedge clk);
			pen <= 1'h1;
			@(posedge clk);
			while (prdy !== 1'h1) @(posedge clk);
			rv = prd;
			err = perr;
			psel <= 1'h0;
			pen <= 1'h0;
		end
	endtask
	task mem(input [7:0] ix);
		begin
			apb(1'h1, 12'h010, {24'h0, ix});
			apb(1'h0, 12'h014, 32'h0);
		end
	endtask
	task lw(input [7:0] ix, input integer n, input [7:0] d);
		begin
			host_u.start;
			host_u.wbyte(8'h66, a);
			chk("ack", a, 1'h1);
			host_u.wbyte(ix, a);
			for (k = 0; k < n; k = k + 1) begin
				chk("ack", a, 1'h1);
				host_u.wbyte(d + 8'h11 * k[7:0], a);
			end
			chk("ack", a, 1'h1);
			host_u.stop;
		end
	endtask
	task lr(input ix_on, input [7:0] ix, input integer n, input [7:0] d);
		begin
			if (ix_on) begin
				host_u.start;
				host_u.wbyte(8'h66, a);
				host_u.wbyte(ix, a);
			end
			host_u.start;
			host_u.wbyte(8'h67, a);
			chk("rd ack", a, 1'h1);
			for (k = 0; k < n; k = k + 1) begin
				host_u.rbyte(k == n - 1, b);
				chk("rd", b, d + 8'h11 * k[7:0]);
			end
			host_u.stop;
		end
	endtask
	task do_reset;
		begin
			rst_n <= 1'h0;
			repeat (16) @(posedge clk);
			rst_n <= 1'h1;
			repeat (10) @(posedge clk);
		end
	endtask
	// ==========
	// Scenarios
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			finish_test;
		end
	end
	initial begin
		{rst_n, psel, pen, pwr, pa, pwd} = 48'h0;
		{ms, hs, ast, pw, flt, asn, ee, e1, e0} = 9'h021;
		do_reset;
		apb(1'h0, 12'h000, 32'h0);
		chk("ctrl", rv, 32'h0000_0033);
		apb(1'h0, 12'h020, 32'h0);
		chk("unmapped", {rv[30:0], err}, 32'h0000_0001);
		chk("esel", esel, 3'h1);
		lw(8'h10, 1, 8'ha5);
		mem(8'h10);
		chk("mem", rv, 32'h0000_00a5);
		apb(1'h0, 12'h004, 32'h0);
		chk("stat", {rv[30:0], irq}, 32'h0000_000a);
		apb(1'h1, 12'h008, 32'h0000_0004);
		apb(1'h0, 12'h008, 32'h0);
		chk("irq", irq, 1'h1);
		apb(1'h1, 12'h004, 32'h0000_0005);
		apb(1'h0, 12'h004, 32'h0);
		chk("clear", {rv[30:0], irq}, 32'h0);
		lw(8'hfe, 3, 8'h11);
		for (i = 0; i < 3; i = i + 1) begin
			mem(8'hfe + i[7:0]);
			chk("wrap", rv, 32'h0000_0011 * (i + 1));
		end
		lr(1'h1, 8'hfe, 3, 8'h11);
		apb(1'h0, 12'h004, 32'h0);
		chk("stat rd", rv, 32'h0000_0007);
		lw(8'h10, 0, 8'h00);
		apb(1'h0, 12'h00c, 32'h0);
		chk("ptr", rv[7:0], 8'h10);
		mem(8'h10);
		chk("kept", rv, 32'h0000_00a5);
		for (i = 0; i < 2; i = i + 1)
			lr(1'h0, 8'h00, 1, 8'ha5);
		host_u.start;
		host_u.wbyte(8'h68, a);
		host_u.stop;
		chk("other", a, 1'h0);
		for (i = 0; i < 2; i = i + 1) begin
			@(posedge clk);
			{ms, ast, hs} <= {2'h3, i[0]};
			do_reset;
			host_u.start;
			host_u.wbyte(8'h66, a);
			host_u.stop;
			chk("alone", a, 1'h0);
			@(posedge clk);
			flt <= 1'h1;
			repeat (8) @(posedge clk);
			chk("fault", {fn_n, sw}, 2'h0);
			flt <= 1'h0;
			repeat (8) @(posedge clk);
			chk("hold", fn_n, !i[0]);
		end
		pw <= 1'h0;
		asn <= 1'h1;
		repeat (8) @(posedge clk);
		chk("attach", ad_n, 1'h0);
		pw <= 1'h1;
		repeat (8) @(posedge clk);
		chk("recover", {fn_n, sw}, 2'h3);
		finish_test;
	end
endmodule // test_smbus_client_register_access
bind scra_client scra_client_props chk_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
	.psel_in(psel_in), .penable_in(penable_in), .prdata_out(prdata_out),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .scl_in(scl_in),
	.sda_oe_n_out(sda_oe_n_out), .interface_mode_strap_in(interface_mode_strap_in),
	.port_power_enable_in(port_power_enable_in), .port_switch_on_out(port_switch_on_out));
